/* File: src/btu_mem.sv */
// Trace record store: one write port, one registered read port
`timescale 1ns/100ps
module btu_mem #(
  parameter int W = 36,
  parameter int DEPTH = 131072,
  parameter int AW = 17
) (
  input wire logic clk,
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [W-1:0] wdata,
  input wire logic [AW-1:0] raddr,
  output logic [W-1:0] rdata
);
  logic [W-1:0] mem [DEPTH]; // Storage array

  // Write and registered read
  always_ff @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end
endmodule // btu_mem

/* File: src/btu_pkg.sv */
// Package: register map, field layout and reset values of the break and trace unit
package btu_pkg;
  // ----------------------------------------
  // Register byte offsets
  // ----------------------------------------
  localparam logic [7:0] OFF_CTRL = 8'h00; // Trace control
  localparam logic [7:0] OFF_TADDR = 8'h04; // Trace condition address
  localparam logic [7:0] OFF_STAT = 8'h08; // Trace and run status
  localparam logic [7:0] OFF_COUNT = 8'h0C; // Valid record count
  localparam logic [7:0] OFF_WPTR = 8'h10; // Next write slot
  localparam logic [7:0] OFF_RIDX = 8'h14; // Record read index
  localparam logic [7:0] OFF_RADDR = 8'h18; // Record address
  localparam logic [7:0] OFF_RATTR = 8'h1C; // Record attributes
  localparam logic [7:0] OFF_CAUSE = 8'h20; // Cause of last break
  localparam logic [7:0] OFF_IRQST = 8'h24; // Sticky event status
  localparam logic [7:0] OFF_IRQEN = 8'h28; // Event enable
  localparam logic [7:0] OFF_IRQCL = 8'h2C; // Event clear, write only
  localparam logic [7:0] OFF_HALT = 8'h30; // Forced break, write only
  localparam logic [1:0] CH_REGION = 2'h1; // paddr[7:6] of channel block
  localparam logic [1:0] CH_ADDR = 2'h0; // Channel: compare address
  localparam logic [1:0] CH_PASS = 2'h1; // Channel: pass count
  localparam logic [1:0] CH_CFG = 2'h2; // Channel: configuration
  localparam logic [1:0] CH_CNT = 2'h3; // Channel: current count
  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int CTRL_FREE = 0; // Free trace enable
  localparam int CTRL_CLEAR = 1; // Clear trace buffer, self clearing
  localparam int CTRL_ACQ = 2; // Action: 0 stop trace, 1 acquire
  localparam int CTRL_TDC = 3; // Trace address don't care
  localparam int STAT_STOP = 0; // Trace stopped
  localparam int STAT_WRAP = 1; // Buffer has wrapped
  localparam int STAT_RUN = 2; // Target running
  localparam int STAT_BRK = 3; // Break pending
  localparam int CFG_EN = 0; // Channel enable
  localparam int CFG_ADC = 1; // Address don't care
  localparam int CFG_CDC = 2; // Count don't care
  localparam int EV_BRK = 0; // Break requested
  localparam int EV_TSTOP = 1; // Trace stopped
  localparam int EV_WRAP = 2; // Buffer wrapped
  localparam int NEV = 3; // Number of events
  localparam int REC_WR = 32; // Record: write cycle
  localparam int REC_SZ = 33; // Record: size, two bits
  localparam int REC_FETCH = 35; // Record: instruction fetch
  localparam int REC_W = 36; // Record width
  // ----------------------------------------
  // Reset values and sizes
  // ----------------------------------------
  localparam logic [3:0] CTRL_RST = 4'h1; // Free trace on after reset
  localparam int TRACE_DEPTH = 131072; // Records in trace store
  localparam int PASS_W = 16; // Pass counter width
  localparam int CH_MAX = 4; // Channels addressable in the map
endpackage

/* File: src/btu_top.sv */
// Break channels, cause of break and real-time bus trace with APB registers
// Behaviour
// - Channel breaks after pass count matches reached
// - Address and count checks each don't-care
// - Cause of latest break kept for host
// - Trace store holds 131072 records
// - Trace written each cycle, never stalls bus
// - Clear request empties trace buffer
// - Free trace records run start to break
// - Free trace overrides condition channel
// - Trace stop freezes buffer on match
// - Trace stop never halts target
// - Acquisition mode records only matching cycles
// - Condition action selectable: stop or acquire
// - Condition matches fetches and data accesses
// - Records carry direction and access size
//
// The APB register port and the address map were decided locally.
`timescale 1ns/100ps
module btu_top
  import btu_pkg::*;
#(
  parameter int NCH = 2, // Break channels, at most CH_MAX
  parameter int DEPTH = btu_pkg::TRACE_DEPTH, // Trace records
  parameter int AW = $clog2(DEPTH) // Record index width
) (
  input wire logic clk,
  input wire logic rst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Target bus monitor, same clock
  input wire logic bus_valid,
  input wire logic [31:0] bus_addr,
  input wire logic bus_write,
  input wire logic [1:0] bus_size,
  input wire logic bus_fetch,
  input wire logic cpu_running,
  // To target and host
  output logic break_req,
  output logic irq
);
  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  logic [3:0] ctrl; // Trace control bits
  logic [31:0] taddr; // Trace condition address
  logic [31:0] ch_addr [NCH]; // Channel compare address
  logic [PASS_W-1:0] ch_pass [NCH]; // Channel pass count
  logic [2:0] ch_cfg [NCH]; // Channel configuration
  logic [PASS_W-1:0] ch_cnt [NCH]; // Channel match count
  logic [NCH-1:0] ch_match; // Channel condition met this cycle
  logic [NCH-1:0] ch_hit; // Channel asks for a break
  logic [NCH:0] cause; // Host halt bit above channel bits
  logic brk_pend; // Break issued, not yet resumed
  logic run_d; // Running, one cycle late
  logic run_start; // Program starts running
  logic host_halt; // Forced break written
  logic tmatch; // Trace condition met
  logic tstopped; // Trace frozen
  logic tr_we; // Record written this cycle
  logic tstop_ev; // Trace stop occurs
  logic wrap_ev; // Oldest record overwritten
  logic wrapped; // Buffer has wrapped
  logic [AW-1:0] wptr; // Next write slot
  logic [AW:0] tcount; // Valid records
  logic [AW-1:0] ridx; // Read index
  logic [REC_W-1:0] rrec; // Record at read index
  logic [NEV-1:0] ev; // Events this cycle
  logic [NEV-1:0] ev_stat; // Sticky events
  logic [NEV-1:0] ev_en; // Event enables
  logic wr_acc; // APB write in access phase
  logic rd_setup; // APB setup phase
  logic clr_req; // Trace clear written
  logic [31:0] next_rdata; // Read value for setup address
  logic next_err; // Unmapped address

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  // True when the address falls in the channel block and names a channel below NCH
  function automatic logic is_ch(input logic [7:0] a);
    return (a[7:6] == CH_REGION) && (int'(a[5:4]) < NCH);
  endfunction

  // Channel number from an address in the channel block
  function automatic int ch_of(input logic [7:0] a);
    return int'(a[5:4]);
  endfunction

  assign wr_acc = psel & penable & pwrite;
  assign rd_setup = psel & ~penable;
  assign clr_req = wr_acc && paddr == OFF_CTRL && pwdata[CTRL_CLEAR];
  assign host_halt = wr_acc && paddr == OFF_HALT && pwdata[0];
  assign run_start = cpu_running & ~run_d;

  // ----------------------------------------
  // APB register writes
  // ----------------------------------------
  // Trace control, condition address, read index, enables
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl <= CTRL_RST;
      taddr <= 32'h0000_0000;
      ridx <= '0;
      ev_en <= '0;
    end else if (wr_acc) begin
      unique case (paddr)
        OFF_CTRL: ctrl <= pwdata[3:0] & ~(4'h1 << CTRL_CLEAR); // Clear bit self clears
        OFF_TADDR: taddr <= pwdata;
        OFF_RIDX: ridx <= pwdata[AW-1:0];
        OFF_IRQEN: ev_en <= pwdata[NEV-1:0];
        default: ; // Halt, event clear and channel writes handled elsewhere; others ignored
      endcase
    end
  end

  // Channel setup registers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < NCH; i++) begin
        ch_addr[i] <= 32'h0000_0000;
        ch_pass[i] <= '0;
        ch_cfg[i] <= 3'h0;
      end
    end else if (wr_acc && is_ch(paddr)) begin
      unique case (paddr[3:2])
        CH_ADDR: ch_addr[ch_of(paddr)] <= pwdata;
        CH_PASS: ch_pass[ch_of(paddr)] <= pwdata[PASS_W-1:0];
        CH_CFG: ch_cfg[ch_of(paddr)] <= pwdata[2:0];
        CH_CNT: ; // Count is read only
      endcase
    end
  end

  // ----------------------------------------
  // Break channels
  // ----------------------------------------
  // Match and pass-count checks; a disabled check counts as met
  always_comb begin
    for (int i = 0; i < NCH; i++) begin
      ch_match[i] = ch_cfg[i][CFG_EN] & bus_valid & cpu_running &
                    (ch_cfg[i][CFG_ADC] | bus_addr == ch_addr[i]);
      ch_hit[i] = ch_match[i] & (ch_cfg[i][CFG_CDC] |
                  (ch_cnt[i] + 1'b1 >= ch_pass[i]));
    end
  end

  // Count matches per channel, restart on each run
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < NCH; i++) begin
        ch_cnt[i] <= '0;
      end
    end else begin
      for (int i = 0; i < NCH; i++) begin
        if (run_start) begin
          ch_cnt[i] <= '0;
        end else if (ch_match[i] && ch_cnt[i] != '1) begin
          ch_cnt[i] <= ch_cnt[i] + 1'b1;
        end
      end
    end
  end

  // Run edge tracker
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      run_d <= 1'b0;
    end else begin
      run_d <= cpu_running;
    end
  end

  // Break request pulse and cause of break
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      break_req <= 1'b0;
      brk_pend <= 1'b0;
      cause <= '0;
    end else begin
      break_req <= 1'b0;
      if (run_start) begin
        brk_pend <= 1'b0; // Resumed: arm again
      end else if (!brk_pend && (|ch_hit || host_halt)) begin
        break_req <= 1'b1;
        brk_pend <= 1'b1;
        cause <= {host_halt, ch_hit};
      end
    end
  end

  // ----------------------------------------
  // Trace acquisition
  // ----------------------------------------
  // Condition on any cycle type, fetch or data
  assign tmatch = ctrl[CTRL_TDC] | bus_addr == taddr;

  // Record gating by mode
  always_comb begin
    tr_we = 1'b0;
    tstop_ev = 1'b0;
    if (cpu_running && bus_valid && !tstopped) begin
      if (ctrl[CTRL_FREE]) begin
        tr_we = 1'b1;
      end else if (ctrl[CTRL_ACQ]) begin
        tr_we = tmatch;
      end else begin
        tr_we = 1'b1; // Record up to and including the match
        tstop_ev = tmatch;
      end
    end
  end

  assign wrap_ev = tr_we && tcount == (AW + 1)'(DEPTH);

  // Write pointer, count and trace state
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wptr <= '0;
      tcount <= '0;
      wrapped <= 1'b0;
      tstopped <= 1'b0;
    end else if (clr_req) begin
      wptr <= '0;
      tcount <= '0;
      wrapped <= 1'b0;
      tstopped <= 1'b0;
    end else begin
      if (run_start) begin
        tstopped <= 1'b0;
      end else if (tstop_ev) begin
        tstopped <= 1'b1;
      end
      if (tr_we) begin
        wptr <= (wptr == AW'(DEPTH - 1)) ? '0 : wptr + 1'b1;
        if (wrap_ev) begin
          wrapped <= 1'b1;
        end else begin
          tcount <= tcount + 1'b1;
        end
      end
    end
  end

  // Record store
  btu_mem #(
    .W(REC_W),
    .DEPTH(DEPTH),
    .AW(AW)
  ) u_mem (
    .clk(clk),
    .we(tr_we),
    .waddr(wptr),
    .wdata({bus_fetch, bus_size, bus_write, bus_addr}),
    .raddr(ridx),
    .rdata(rrec)
  );

  // ----------------------------------------
  // Events and interrupt
  // ----------------------------------------
  always_comb begin
    ev = '0;
    ev[EV_BRK] = !brk_pend && !run_start && (|ch_hit || host_halt);
    ev[EV_TSTOP] = tstop_ev & ~clr_req & ~run_start;
    ev[EV_WRAP] = wrap_ev & ~clr_req;
  end

  // Sticky status, set beats clear
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ev_stat <= '0;
    end else if (wr_acc && paddr == OFF_IRQCL) begin
      ev_stat <= (ev_stat & ~pwdata[NEV-1:0]) | ev;
    end else begin
      ev_stat <= ev_stat | ev;
    end
  end

  // Level interrupt
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(ev_stat & ev_en);
    end
  end

  // ----------------------------------------
  // APB read path
  // ----------------------------------------
  // Read value for the setup address
  always_comb begin
    next_rdata = 32'h0000_0000;
    next_err = 1'b0;
    if (is_ch(paddr)) begin
      unique case (paddr[3:2])
        CH_ADDR: next_rdata = ch_addr[ch_of(paddr)];
        CH_PASS: next_rdata[PASS_W-1:0] = ch_pass[ch_of(paddr)];
        CH_CFG: next_rdata[2:0] = ch_cfg[ch_of(paddr)];
        CH_CNT: next_rdata[PASS_W-1:0] = ch_cnt[ch_of(paddr)];
      endcase
    end else begin
      unique case (paddr)
        OFF_CTRL: next_rdata[3:0] = ctrl;
        OFF_TADDR: next_rdata = taddr;
        OFF_STAT: begin
          next_rdata[STAT_STOP] = tstopped;
          next_rdata[STAT_WRAP] = wrapped;
          next_rdata[STAT_RUN] = cpu_running;
          next_rdata[STAT_BRK] = brk_pend;
        end
        OFF_COUNT: next_rdata[AW:0] = tcount;
        OFF_WPTR: next_rdata[AW-1:0] = wptr;
        OFF_RIDX: next_rdata[AW-1:0] = ridx;
        OFF_RADDR: next_rdata = rrec[31:0];
        OFF_RATTR: next_rdata[3:0] = rrec[REC_W-1:REC_WR];
        OFF_CAUSE: next_rdata[NCH:0] = cause;
        OFF_IRQST: next_rdata[NEV-1:0] = ev_stat;
        OFF_IRQEN: next_rdata[NEV-1:0] = ev_en;
        OFF_IRQCL, OFF_HALT: ; // Write only, read zero
        default: next_err = 1'b1; // Unmapped
      endcase
    end
  end

  // Answer registered in setup, valid through the access phase
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
      pready <= 1'b0;
    end else begin
      pready <= 1'b1;
      if (rd_setup) begin
        prdata <= pwrite ? 32'h0000_0000 : next_rdata;
        pslverr <= next_err;
      end
    end
  end
endmodule // btu_top

/* File: tb/btu_chk.sv */
// Checker: port-level assertions of the break and trace unit
`timescale 1ns/100ps
module btu_chk (
  input wire logic clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic bus_valid,
  input wire logic [31:0] bus_addr,
  input wire logic bus_write,
  input wire logic [1:0] bus_size,
  input wire logic bus_fetch,
  input wire logic cpu_running,
  input wire logic break_req,
  input wire logic irq
);
  import btu_pkg::*;
  logic hit_c; // Cycle that may hit a channel
  logic halt_c; // Forced break write
  assign hit_c = bus_valid && cpu_running;
  assign halt_c = psel && penable && pwrite && paddr == OFF_HALT;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  chk_ready_rise: assert property (!pready |=> pready)
    else $error("pready did not rise");
  chk_access_ready: assert property (psel && penable |-> pready)
    else $error("access phase without pready");
  chk_break_pulse: assert property (break_req |=> !break_req)
    else $error("break request longer than one cycle");
  chk_break_cause: assert property ($rose(break_req) |->
    $past(hit_c) || $past(halt_c) || $past(halt_c, 2))
    else $error("break request without a cause");
  chk_unmapped_err: assert property (psel && !penable && paddr == 8'hFC |=>
    pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");
  chk_mapped_ok: assert property (psel && !penable && paddr == OFF_CTRL |=> !pslverr)
    else $error("mapped access refused");
  chk_rdata_hold: assert property (psel && penable |=> $stable(prdata))
    else $error("read data moved after access");
  chk_irq_mask: assert property (psel && penable && pwrite && paddr == OFF_IRQEN
    && pwdata == 32'h0 |-> ##2 !irq)
    else $error("masked interrupt still high");
endmodule // btu_chk
bind btu_top btu_chk btu_chk_i (.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .bus_valid(bus_valid), .bus_addr(bus_addr), .bus_write(bus_write), .bus_size(bus_size),
  .bus_fetch(bus_fetch), .cpu_running(cpu_running), .break_req(break_req), .irq(irq));

/* File: tb/btu_tgt.sv */
// Target bus model: bus cycles and run level of the emulated CPU
`timescale 1ns/100ps
module btu_tgt (
  input wire logic cyc_on,
  input wire logic [31:0] cyc_addr,
  input wire logic cyc_write,
  input wire logic [1:0] cyc_size,
  input wire logic cyc_fetch,
  input wire logic run_on,
  output logic bus_valid,
  output logic [31:0] bus_addr,
  output logic bus_write,
  output logic [1:0] bus_size,
  output logic bus_fetch,
  output logic cpu_running
);
  // Bus cycle stands while requested
  assign bus_valid = cyc_on;
  // Idle lines show the inverse, not a stale copy
  assign bus_addr = cyc_on ? cyc_addr : ~cyc_addr;
  assign bus_write = cyc_on ? cyc_write : ~cyc_write;
  assign bus_size = cyc_on ? cyc_size : ~cyc_size;
  assign bus_fetch = cyc_on ? cyc_fetch : ~cyc_fetch;
  // Run level of the user program
  assign cpu_running = run_on;
endmodule // btu_tgt

/* File: tb/tb_top.sv */
// Testbench: APB sequences over the break and trace unit
`timescale 1ns/100ps
module tb_top;
  import btu_pkg::*;
  localparam int DP = 16; // Shortened trace depth
  logic clk, rst, psel, penable, pwrite, pready, pslverr, ev;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rv, bus_addr;
  logic bus_valid, bus_write, bus_fetch, cpu_running, break_req, irq;
  logic [1:0] bus_size;
  logic cyc_on, cyc_write, cyc_fetch, run_on; // Target model requests
  logic [31:0] cyc_addr;
  logic [1:0] cyc_size;
  int bad_count = 0, samples_checked = 0, brk_n = 0, tick = 0;
  btu_top #(.DEPTH(DP)) btu_top_i (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .bus_valid(bus_valid), .bus_addr(bus_addr), .bus_write(bus_write),
    .bus_size(bus_size), .bus_fetch(bus_fetch), .cpu_running(cpu_running),
    .break_req(break_req), .irq(irq));
  btu_tgt btu_tgt_i (.cyc_on(cyc_on), .cyc_addr(cyc_addr), .cyc_write(cyc_write), .cyc_size(cyc_size),
    .cyc_fetch(cyc_fetch), .run_on(run_on), .bus_valid(bus_valid), .bus_addr(bus_addr),
    .bus_write(bus_write), .bus_size(bus_size), .bus_fetch(bus_fetch), .cpu_running(cpu_running));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // Break pulse counter and run limit
  always @(posedge clk) begin
    tick <= tick + 1;
    if (break_req === 1'b1) begin
      brk_n <= brk_n + 1;
    end
    if (tick == 20000) begin
      bad_count++;
      final_report();
    end
  end
  task automatic final_report();
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // One APB transfer, held until pready at an access edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rv = prdata;
    ev = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    cmp(rv, exp);
  endtask
  // Read back one trace record
  task automatic rec(input logic [31:0] i, input logic [31:0] a, input logic [31:0] t);
    wr(OFF_RIDX, i);
    repeat (2) @(posedge clk);
    rd(OFF_RADDR, a);
    rd(OFF_RATTR, t);
  endtask
  // One target bus cycle, then an idle cycle
  task automatic cyc(input logic [31:0] a, input logic w, input logic [1:0] s, input logic f);
    @(posedge clk);
    cyc_on <= 1'b1;
    cyc_addr <= a;
    cyc_write <= w;
    cyc_size <= s;
    cyc_fetch <= f;
    @(posedge clk);
    cyc_on <= 1'b0;
  endtask
  // Start or stop user program execution
  task automatic run(input logic on);
    @(posedge clk);
    run_on <= on;
  endtask
  task automatic cy(input logic [31:0] a);
    cyc(a, 1'b0, 2'h2, 1'b0);
  endtask
  task automatic ick(input logic e);
    repeat (2) @(posedge clk);
    cmp({31'h0, irq}, {31'h0, e});
  endtask
  initial begin
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    cyc_on = 1'b0;
    cyc_addr = 32'h0;
    cyc_write = 1'b0;
    cyc_size = 2'h0;
    cyc_fetch = 1'b0;
    run_on = 1'b0;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    rd(OFF_CTRL, 32'h1);
    rd(OFF_COUNT, 32'h0);
    // Free trace with acquire action set: all cycles kept
    wr(OFF_TADDR, 32'hFFFF0400);
    wr(OFF_CTRL, 32'h5);
    run(1'b1);
    cyc(32'h100, 1'b1, 2'h2, 1'b0);
    cyc(32'h104, 1'b0, 2'h1, 1'b1);
    cyc(32'h108, 1'b0, 2'h0, 1'b0);
    run(1'b0);
    rd(OFF_COUNT, 32'h3);
    rec(1, 32'h104, 32'hA);
    rec(0, 32'h100, 32'h5);
    // Clear, then acquisition of one address, data and fetch cycles
    wr(OFF_CTRL, 32'h6);
    rd(OFF_COUNT, 32'h0);
    rd(OFF_WPTR, 32'h0);
    run(1'b1);
    cy(32'hFFFF0400);
    cy(32'h110);
    cyc(32'hFFFF0400, 1'b1, 2'h2, 1'b0);
    cyc(32'hFFFF0400, 1'b0, 2'h1, 1'b1);
    run(1'b0);
    rd(OFF_COUNT, 32'h3);
    rd(OFF_STAT, 32'h0);
    rec(0, 32'hFFFF0400, 32'h4);
    rec(2, 32'hFFFF0400, 32'hA);
    // Trace stop: freeze after the match, target keeps running
    wr(OFF_CTRL, 32'h2);
    run(1'b1);
    cy(32'h120);
    cy(32'hFFFF0400);
    cy(32'h124);
    rd(OFF_STAT, 32'h5);
    run(1'b0);
    rd(OFF_COUNT, 32'h2);
    cmp(brk_n, 0);
    rd(OFF_IRQST, 32'h2);
    // Interrupt raised, masked, cleared
    wr(OFF_IRQEN, 32'h2);
    ick(1'b1);
    wr(OFF_IRQEN, 32'h0);
    ick(1'b0);
    wr(OFF_IRQEN, 32'h2);
    wr(OFF_IRQCL, 32'h2);
    ick(1'b0);
    rd(OFF_IRQST, 32'h0);
    // Overfill the store: oldest records overwritten
    wr(OFF_CTRL, 32'h3);
    run(1'b1);
    for (int i = 0; i < DP + 2; i++) begin
      cy(32'h300 + i);
    end
    run(1'b0);
    rd(OFF_COUNT, DP);
    rd(OFF_WPTR, 32'h2);
    rec(2, 32'h302, 32'h4);
    rd(OFF_STAT, 32'h2);
    rd(OFF_IRQST, 32'h4);
    // Channel 0 breaks on the fifth address match
    wr(8'h40, 32'h200);
    wr(8'h44, 32'h5);
    wr(8'h48, 32'h1);
    run(1'b1);
    for (int i = 0; i < 4; i++) begin
      cy(32'h200);
      cy(32'h204);
    end
    cmp(brk_n, 0);
    cy(32'h200);
    repeat (2) @(posedge clk);
    cmp(brk_n, 1);
    cy(32'h200);
    rd(OFF_CAUSE, 32'h1);
    cmp(brk_n, 1);
    // Channel 1 with both checks don't care
    run(1'b0);
    wr(8'h48, 32'h0);
    wr(8'h58, 32'h7);
    run(1'b1);
    cy(32'h999);
    repeat (2) @(posedge clk);
    cmp(brk_n, 2);
    rd(OFF_CAUSE, 32'h2);
    // Forced halt in a fresh run
    run(1'b0);
    run(1'b1);
    wr(OFF_HALT, 32'h1);
    repeat (2) @(posedge clk);
    cmp(brk_n, 3);
    rd(OFF_CAUSE, 32'h4);
    run(1'b0);
    rd(OFF_IRQST, 32'h5);
    // Acquisition with trace address don't care: every cycle kept
    wr(OFF_CTRL, 32'hE);
    rd(OFF_CTRL, 32'hC);
    run(1'b1);
    cy(32'h500);
    run(1'b0);
    rd(OFF_COUNT, 32'h1);
    rec(0, 32'h500, 32'h4);
    rd(8'hFC, 32'h0);
    cmp({31'h0, ev}, 32'h1);
    final_report();
  end
endmodule // tb_top
